// ==== design/rtilm_defs.svh ====
// Purpose: offsets, field positions, reset values for the log block
// Assumes: 16-bit shared RAM addresses, 32-bit Avalon-MM data
// Notes:   included by bare name
`ifndef RTILM_DEFS_SVH
`define RTILM_DEFS_SVH
// Interrupt log ring
`define RTILM_LOG_BASE   8'h40
`define RTILM_CNT_MAX    8'hFF
// Descriptor table and quadrant offsets in words
`define RTILM_TBL_BASE   16'h0200
`define RTILM_Q_RX_SA    16'h0000
`define RTILM_Q_TX_SA    16'h0080
`define RTILM_Q_RX_MC    16'h0100
`define RTILM_Q_TX_MC    16'h0180
// Register word offsets
`define RTILM_R_LOGPTR   3'h0
`define RTILM_R_INTEN    3'h1
`define RTILM_R_CURCW    3'h2
`define RTILM_R_CTRL     3'h3
`define RTILM_R_STAT     3'h4
// Field positions and reset values
`define RTILM_CTRL_SOFTWARE_RESET_BIT  0
`define RTILM_IXEQZ_BIT  7
`define RTILM_CW_PP_BIT  4
`define RTILM_INTEN_RST  16'h0000
`endif

// ==== design/rtilm_pkg.sv ====
// Purpose: types shared by the log block files
// Assumes: nothing
// Notes:   constants live in rtilm_defs.svh
package rtilm_pkg;
  // Log writer states, one-hot
  typedef enum logic [3:0] {
    RTILM_IDLE = 4'h1,
    RTILM_CW   = 4'h2,
    RTILM_ID   = 4'h4,
    RTILM_SRC  = 4'h8
  } rtilm_state_t;
  // Buffer method from the control word
  typedef enum logic [1:0] {
    RTILM_INDEXED  = 2'h0,
    RTILM_PINGPONG = 2'h1,
    RTILM_CIRC1    = 2'h2,
    RTILM_CIRC2    = 2'h3
  } rtilm_method_t;
endpackage

// ==== design/rtilm_desc_addr.sv ====
// Purpose: command word to descriptor control word address
// Assumes: table base given as parameter
// Notes:   purely combinational
`timescale 1ns/10ps
`include "rtilm_defs.svh"
module rtilm_desc_addr #(
  parameter logic [15:0] TBL_BASE = `RTILM_TBL_BASE
) (
  input  wire logic [15:0] i_cmd_word,
  output logic      [15:0] o_cw_addr,
  output logic             o_mode,
  output logic      [5:0]  o_word_count
);
  logic [4:0]  sa;
  logic [4:0]  idx;
  logic [15:0] qofs;

  // Field split and mode detect
  assign sa     = i_cmd_word[9:5];
  assign o_mode = (sa == 5'h00) || (sa == 5'h1F);
  // Mode quadrants index by mode code, others by subaddress
  assign idx = o_mode ? i_cmd_word[4:0] : sa;
  // Zero count field means 32 words
  assign o_word_count = (i_cmd_word[4:0] == 5'h00) ? 6'h20 :
                        {1'b0, i_cmd_word[4:0]};

  // Quadrant select by mode and T/R bit
  always_comb begin
    unique case ({o_mode, i_cmd_word[10]})
      2'b00: qofs = `RTILM_Q_RX_SA;
      2'b01: qofs = `RTILM_Q_TX_SA;
      2'b10: qofs = `RTILM_Q_RX_MC;
      2'b11: qofs = `RTILM_Q_TX_MC;
    endcase
  end

  // Control word is word 0 of a 4-word block
  assign o_cw_addr = TBL_BASE + qofs
                     + {9'h000, idx, 2'b00};
endmodule

// ==== design/rtilm_top.sv ====
// Purpose: interrupt log ring writer and descriptor addressing
// Assumes: single RAM write port with wait; Avalon-MM register slave
// Notes:   master reset is i_rst, software reset is a control bit
// Function
// - Message interrupt source word is its control word address.
// - Hardware interrupt source word is all zeros.
// - Either reset loads pointer byte with ring base.
// - Pointer byte reads even, within base up to last entry slot.
// - Pointer byte shows where the next identification word goes.
// - Identification word at pointer, source next; advance per word.
// - Sixteenth entry ends the ring; pointer wraps to offset zero.
// - Upper byte counts logged events; reading it restarts count.
// - Event count saturates at maximum, never wraps.
// - Descriptor table holds 128 blocks of four words.
// - Subaddress 1-30 uses receive or transmit subaddress quadrant.
// - Subaddress 0 or 31 is a mode command, mode quadrants.
// - Padding blocks for subaddress 0 and 31 are never used.
// - Mode quadrants index by mode code, others by subaddress.
// - Current control word address register holds latest command.
// - Control word is first word; method governs the rest.
// - After processing, control word is written back per method.
// - Indexed method may interrupt when all messages completed.
// - Ping-pong alternates buffers on successive messages.
// - Circular mode 1 may interrupt when buffer is full.
// - Circular mode 2 may interrupt when message count done.
// - Subaddress commands carry 1 to 32 data words.
// - Identification word keeps only occurring interrupt bits.
// - Interrupt type logged only when its enable bit set.
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "rtilm_defs.svh"
module rtilm_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_cmd_valid,
  input  wire logic [15:0] i_cmd_word,
  output logic      [5:0]  o_word_count,
  output logic             o_mode_cmd,
  input  wire logic        i_msg_done,
  input  wire logic [7:0]  i_msg_int,
  input  wire logic [1:0]  i_msg_method,
  input  wire logic [15:0] i_msg_cw,
  input  wire logic [7:0]  i_hw_int,
  output logic             o_ram_wr,
  output logic      [15:0] o_ram_addr,
  output logic      [15:0] o_ram_wdata,
  input  wire logic        i_ram_wait,
  output logic             o_busy
);
  rtilm_pkg::rtilm_state_t state_q;
  logic [4:0]  ptr_q;
  logic [7:0]  cnt_q;
  logic [15:0] inten_q;
  logic [15:0] cur_cw_q;
  logic [7:0]  msg_pend_q;
  logic [15:0] msg_src_q;
  logic [7:0]  hw_pend_q;
  logic        cw_pend_q;
  logic [15:0] cw_addr_q;
  logic [15:0] cw_data_q;
  logic        ent_msg_q;
  logic [15:0] ent_src_q;
  logic        ack_q;
  logic        software_reset_bit;
  logic        wr_en;
  logic        rd_clr;
  logic        word_ok;
  logic        ent_done;
  logic        take_cw;
  logic        take_ent;
  logic        take_msg;
  logic [7:0]  msg_new;
  logic [7:0]  hw_new;
  logic [7:0]  ptr_byte;
  logic [4:0]  ptr_nx;
  logic [15:0] dt_addr;
  logic        dt_mode;
  logic [5:0]  dt_wc;
  logic [31:0] rdata;

  // Descriptor address decode of the incoming command
  rtilm_desc_addr u_desc (
    .i_cmd_word   (i_cmd_word),
    .o_cw_addr    (dt_addr),
    .o_mode       (dt_mode),
    .o_word_count (dt_wc)
  );

  // Bus handshake: one wait cycle per access
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign wr_en  = i_avs_write & ack_q;
  assign software_reset_bit   = wr_en && (i_avs_address[4:2] == `RTILM_R_CTRL)
                  && i_avs_byteenable[0]
                  && i_avs_writedata[`RTILM_CTRL_SOFTWARE_RESET_BIT];
  // Count cleared at the capture edge so no event slips by
  assign rd_clr = i_avs_read && !ack_q
                  && (i_avs_address[4:2] == `RTILM_R_LOGPTR);

  // Writer strobes
  assign word_ok  = o_ram_wr & ~i_ram_wait;
  assign ent_done = word_ok && (state_q == rtilm_pkg::RTILM_SRC);
  assign take_cw  = (state_q == rtilm_pkg::RTILM_IDLE) && cw_pend_q;
  assign take_ent = (state_q == rtilm_pkg::RTILM_IDLE) && !cw_pend_q
                    && ((msg_pend_q != 8'h00) || (hw_pend_q != 8'h00));
  assign take_msg = take_ent && (msg_pend_q != 8'h00);
  assign ptr_nx   = ptr_q + 5'h01;
  assign ptr_byte = `RTILM_LOG_BASE + {3'h0, ptr_q[4:1], 1'b0};
  assign o_busy   = (state_q != rtilm_pkg::RTILM_IDLE);

  // Enabled event bits; ping-pong has no end-of-count interrupt
  always_comb begin
    msg_new = 8'h00;
    if (i_msg_done) begin
      msg_new = i_msg_int & inten_q[15:8];
      if (i_msg_method == rtilm_pkg::RTILM_PINGPONG) begin
        msg_new[`RTILM_IXEQZ_BIT] = 1'b0;
      end
    end
  end
  assign hw_new = i_hw_int & inten_q[7:0];

  // Bus acknowledge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  // Read mux, unmapped reads return zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (i_avs_address[4:2])
      `RTILM_R_LOGPTR: rdata = {16'h0000, cnt_q, ptr_byte};
      `RTILM_R_INTEN:  rdata = {16'h0000, inten_q};
      `RTILM_R_CURCW:  rdata = {16'h0000, cur_cw_q};
      `RTILM_R_STAT:   rdata = {30'h0000_0000, cw_pend_q, o_busy};
      default:         rdata = 32'h0000_0000;
    endcase
  end

  // Read data captured while waitrequest is high
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack_q) begin
      o_avs_readdata <= rdata;
    end
  end

  // Interrupt enable register, byte lanes 0 and 1
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      inten_q <= `RTILM_INTEN_RST;
    end else if (wr_en && (i_avs_address[4:2] == `RTILM_R_INTEN)) begin
      if (i_avs_byteenable[0]) begin
        inten_q[7:0] <= i_avs_writedata[7:0];
      end
      if (i_avs_byteenable[1]) begin
        inten_q[15:8] <= i_avs_writedata[15:8];
      end
    end
  end

  // Latest valid command: address and word count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cur_cw_q     <= 16'h0000;
      o_word_count <= 6'h00;
      o_mode_cmd   <= 1'b0;
    end else if (i_cmd_valid) begin
      cur_cw_q     <= dt_addr;
      o_word_count <= dt_wc;
      o_mode_cmd   <= dt_mode;
    end
  end

  // Pending message bits with source; set wins over take
  always_ff @(posedge i_clk) begin
    if (i_rst || software_reset_bit) begin
      msg_pend_q <= 8'h00;
      msg_src_q  <= 16'h0000;
    end else begin
      msg_pend_q <= (take_msg ? 8'h00 : msg_pend_q) | msg_new;
      if (msg_new != 8'h00) begin
        msg_src_q <= cur_cw_q;
      end
    end
  end

  // Pending hardware bits; set wins over take
  always_ff @(posedge i_clk) begin
    if (i_rst || software_reset_bit) begin
      hw_pend_q <= 8'h00;
    end else begin
      hw_pend_q <= ((take_ent && !take_msg) ? 8'h00 : hw_pend_q)
                   | hw_new;
    end
  end

  // Control word write-back request after each message
  always_ff @(posedge i_clk) begin
    if (i_rst || software_reset_bit) begin
      cw_pend_q <= 1'b0;
      cw_addr_q <= 16'h0000;
      cw_data_q <= 16'h0000;
    end else if (i_msg_done) begin
      cw_pend_q <= 1'b1;
      cw_addr_q <= cur_cw_q;
      cw_data_q <= i_msg_cw;
      if (i_msg_method == rtilm_pkg::RTILM_PINGPONG) begin
        cw_data_q[`RTILM_CW_PP_BIT] <= ~i_msg_cw[`RTILM_CW_PP_BIT];
      end
    end else if (take_cw) begin
      cw_pend_q <= 1'b0;
    end
  end

  // Writer state machine
  always_ff @(posedge i_clk) begin
    if (i_rst || software_reset_bit) begin
      state_q <= rtilm_pkg::RTILM_IDLE;
    end else begin
      unique case (state_q)
        rtilm_pkg::RTILM_IDLE: begin
          if (take_cw) begin
            state_q <= rtilm_pkg::RTILM_CW;
          end else if (take_ent) begin
            state_q <= rtilm_pkg::RTILM_ID;
          end
        end
        rtilm_pkg::RTILM_CW: begin
          if (word_ok) begin
            state_q <= rtilm_pkg::RTILM_IDLE;
          end
        end
        rtilm_pkg::RTILM_ID: begin
          if (word_ok) begin
            state_q <= rtilm_pkg::RTILM_SRC;
          end
        end
        rtilm_pkg::RTILM_SRC: begin
          if (word_ok) begin
            state_q <= rtilm_pkg::RTILM_IDLE;
          end
        end
      endcase
    end
  end

  // Entry source: control word address or zero for hardware
  always_ff @(posedge i_clk) begin
    if (i_rst || software_reset_bit) begin
      ent_msg_q <= 1'b0;
      ent_src_q <= 16'h0000;
    end else if (take_ent) begin
      ent_msg_q <= take_msg;
      ent_src_q <= take_msg ? msg_src_q : 16'h0000;
    end
  end

  // RAM write port, held until the RAM stops waiting
  always_ff @(posedge i_clk) begin
    if (i_rst || software_reset_bit) begin
      o_ram_wr    <= 1'b0;
      o_ram_addr  <= 16'h0000;
      o_ram_wdata <= 16'h0000;
    end else if (take_cw) begin
      o_ram_wr    <= 1'b1;
      o_ram_addr  <= cw_addr_q;
      o_ram_wdata <= cw_data_q;
    end else if (take_ent) begin
      o_ram_wr    <= 1'b1;
      o_ram_addr  <= {8'h00, `RTILM_LOG_BASE + {3'h0, ptr_q}};
      o_ram_wdata <= take_msg ? {msg_pend_q, 8'h00}
                              : {8'h00, hw_pend_q};
    end else if (word_ok && (state_q == rtilm_pkg::RTILM_ID)) begin
      o_ram_addr  <= {8'h00, `RTILM_LOG_BASE + {3'h0, ptr_nx}};
      o_ram_wdata <= ent_src_q;
    end else if (word_ok) begin
      o_ram_wr    <= 1'b0;
    end
  end

  // Ring pointer, advanced per logged word, wraps after 32
  always_ff @(posedge i_clk) begin
    if (i_rst || software_reset_bit) begin
      ptr_q <= 5'h00;
    end else if (word_ok && (state_q != rtilm_pkg::RTILM_CW)) begin
      ptr_q <= ptr_nx;
    end
  end

  // Saturating event count, cleared by a read; event wins
  always_ff @(posedge i_clk) begin
    if (i_rst || software_reset_bit) begin
      cnt_q <= 8'h00;
    end else if (rd_clr) begin
      cnt_q <= ent_done ? 8'h01 : 8'h00;
    end else if (ent_done && (cnt_q != `RTILM_CNT_MAX)) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_id_word;
    (state_q == rtilm_pkg::RTILM_ID) && word_ok;
  endsequence
  sequence s_src_next;
    (state_q == rtilm_pkg::RTILM_SRC) && o_ram_wr;
  endsequence

  AST_PTR_EVEN: assert property (
    ptr_byte[0] == 1'b0 && ptr_byte >= 8'h40 && ptr_byte <= 8'h5E)
    else $error("log pointer byte out of ring or odd");
  AST_SOFTWARE_RESET_BIT_PTR: assert property (
    software_reset_bit |=> (ptr_q == 5'h00) && (cnt_q == 8'h00))
    else $error("software reset did not reload pointer");
  AST_ID_THEN_SRC: assert property (
    s_id_word |=> s_src_next
      and (o_ram_addr[7:0] == $past(o_ram_addr[7:0]) + 8'h01
           || o_ram_addr[7:0] == 8'h40))
    else $error("source word not at next ring slot");
  AST_HW_SRC_ZERO: assert property (
    (state_q == rtilm_pkg::RTILM_SRC) && !ent_msg_q
      |-> o_ram_wdata == 16'h0000)
    else $error("hardware entry source word not zero");
  AST_MSG_SRC: assert property (
    take_msg |=> ##[1:300] (state_q == rtilm_pkg::RTILM_SRC)
      && o_ram_wdata == $past(msg_src_q, 1))
    else $error("message source word mismatch");
  AST_WRAP: assert property (
    (ptr_q == 5'h1F) && ent_done |=> ptr_q == 5'h00)
    else $error("ring pointer did not wrap");
  AST_CNT_SAT: assert property (
    (cnt_q == 8'hFF) && !rd_clr && !software_reset_bit |=> cnt_q == 8'hFF)
    else $error("event count wrapped");
  AST_CNT_CLR: assert property (
    rd_clr && !ent_done && !software_reset_bit |=> (cnt_q == 8'h00) && ack_q)
    else $error("read did not restart count");
  AST_CUR_CW: assert property (
    i_cmd_valid |=> cur_cw_q == $past(dt_addr))
    else $error("current control word address stale");
  AST_ID_BITS: assert property (
    take_ent && !take_msg |=> (o_ram_wdata[7:0] & ~inten_q[7:0]) == 8'h00
      || $past(inten_q) != inten_q)
    else $error("disabled hardware bit logged");
endmodule

// ==== bench/rtilm_ram_model.sv ====
// Purpose: shared RAM behind the log writer, with optional stalls
// Assumes: one write port, request held until wait is low
// Notes:   wait toggles while idle so nothing leans on its level
`timescale 1ns/10ps
module rtilm_ram_model (
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_wait
);
  logic [15:0] mem [0:1023];
  logic [1:0]  stall_q;
  logic        idle_q;
  int          writes;
  // Two stall cycles per word when slow; a toggling level when idle
  assign o_wait = i_wr ? (i_slow && stall_q != 2'h2) : idle_q;
  // Fill with a pattern so an unwritten slot never looks right
  initial begin
    idle_q = 1'b0;
    stall_q = 2'h0;
    writes = 0;
    for (int k = 0; k < 1024; k++) mem[k] = ~16'(k);
  end
  // Store the word taken at this edge
  always @(posedge i_clk) begin
    idle_q <= ~idle_q;
    stall_q <= (i_wr && o_wait) ? stall_q + 2'h1 : 2'h0;
    if (i_wr && !o_wait) begin
      mem[i_addr[9:0]] <= i_wdata;
      writes <= writes + 1;
    end
  end
endmodule

// ==== bench/rtilm_tb.sv ====
// Purpose: self-checking bench for the log writer and descriptor map
// Assumes: register access over Avalon-MM, RAM model as far side
// Notes:   ring contents are read from the RAM model
`timescale 1ns/10ps
module rtilm_tb;
  logic        i_clk, i_rst, rd, wr, cmd_v, done, slow;
  logic        waitreq, ram_wr, ram_wait, mode, busy;
  logic [4:0]  adr;
  logic [31:0] wd, rdata, q;
  logic [15:0] cmd, mcw, ram_a, ram_d;
  logic [7:0]  mint, hint;
  logic [1:0]  meth;
  logic [5:0]  wcnt;
  int          errors, checked, cyc, ptr;
  logic [15:0] t_cmd [5] = '{16'h03C0, 16'h07C5, 16'h0000, 16'h07E5,
                             16'h0021};
  logic [15:0] t_adr [5] = '{16'h0278, 16'h02F8, 16'h0300, 16'h0394,
                             16'h0204};
  logic [5:0]  t_wc  [5] = '{6'h20, 6'h05, 6'h00, 6'h00, 6'h01};

  rtilm_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'h3), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_cmd_valid(cmd_v), .i_cmd_word(cmd),
    .o_word_count(wcnt), .o_mode_cmd(mode), .i_msg_done(done),
    .i_msg_int(mint), .i_msg_method(meth), .i_msg_cw(mcw),
    .i_hw_int(hint), .o_ram_wr(ram_wr), .o_ram_addr(ram_a),
    .o_ram_wdata(ram_d), .i_ram_wait(ram_wait), .o_busy(busy));
  rtilm_ram_model i_ram (.i_clk(i_clk), .i_slow(slow), .i_wr(ram_wr),
    .i_addr(ram_a), .i_wdata(ram_d), .o_wait(ram_wait));

  // Clock at 10 MHz
  always #50 i_clk = ~i_clk;
  // Cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // One register access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [15:0] d);
    @(posedge i_clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= {16'h0000, d};
    do @(posedge i_clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Let pending events drain; the writer idles one cycle between jobs
  task automatic idle();
    int quiet;
    quiet = 0;
    repeat (3) @(posedge i_clk);
    while (quiet < 2) begin
      @(posedge i_clk);
      quiet = (busy === 1'b0) ? quiet + 1 : 0;
    end
  endtask
  task automatic hw(input logic [7:0] b);
    @(posedge i_clk);
    hint <= b;
    @(posedge i_clk);
    hint <= 8'h00;
    idle();
  endtask
  task automatic msg(input logic [15:0] c, input logic [1:0] m,
                     input logic [15:0] w);
    @(posedge i_clk);
    cmd <= c;
    cmd_v <= 1'b1;
    @(posedge i_clk);
    cmd_v <= 1'b0;
    done <= 1'b1;
    mint <= 8'h04;
    meth <= m;
    mcw <= w;
    @(posedge i_clk);
    done <= 1'b0;
    idle();
  endtask
  // Compare one two-word entry at the expected ring slot
  task automatic entry(input logic [15:0] id, input logic [15:0] src);
    chk("log id word", id, i_ram.mem[10'h040 + ptr]);
    chk("log source word", src, i_ram.mem[10'h041 + ptr]);
    ptr = (ptr + 2) % 32;
  endtask

  // Main sequence
  initial begin
    i_clk = 0;
    i_rst = 1;
    {rd, wr, cmd_v, done, adr, wd, cmd, mcw, mint, hint, meth} = '0;
    slow = 1;
    ptr = 0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    bus(0, 5'h00, 0);
    chk("log pointer", 16'h0040, q[15:0]);
    bus(1, 5'h04, 16'hFF08);
    bus(0, 5'h04, 0);
    chk("enables", 16'hFF08, q[15:0]);
    hw(8'h0C);
    entry(16'h0008, 16'h0000);
    hw(8'h04);
    chk("ram writes", 16'h0002, i_ram.writes[15:0]);
    bus(0, 5'h00, 0);
    chk("log pointer", 16'h0142, q[15:0]);
    bus(0, 5'h00, 0);
    chk("log pointer", 16'h0042, q[15:0]);
    // Command table across all quadrants and all buffer methods
    for (int i = 0; i < 5; i++) begin
      msg(t_cmd[i], 2'(i % 4), 16'h8010);
      chk("write-back", (i % 4 == 1) ? 16'h8000 : 16'h8010,
          i_ram.mem[t_adr[i][9:0]]);
      bus(0, 5'h08, 0);
      chk("current cw", t_adr[i], q[15:0]);
      chk("mode", {15'h0000, t_wc[i] == 6'h00}, {15'h0000, mode});
      if (t_wc[i] != 6'h00) chk("count", {10'h000, t_wc[i]},
                                {10'h000, wcnt});
      entry(16'h0400, t_adr[i]);
    end
    bus(0, 5'h10, 0);
    chk("status", 16'h0000, q[15:0]);
    chk("pad rx sa0", ~16'h0200, i_ram.mem[10'h200]);
    chk("pad tx sa31", ~16'h02FC, i_ram.mem[10'h2FC]);
    // Read-only, unmapped and write-only places
    bus(1, 5'h08, 16'h1111);
    bus(0, 5'h08, 0);
    chk("current cw", 16'h0204, q[15:0]);
    bus(0, 5'h1C, 0);
    chk("unmapped", 16'h0000, q[15:0]);
    bus(0, 5'h0C, 0);
    chk("control", 16'h0000, q[15:0]);
    // Software reset, then wrap and saturate the count
    slow <= 1'b0;
    bus(1, 5'h04, 16'hFFFF);
    bus(1, 5'h0C, 16'h0001);
    bus(0, 5'h00, 0);
    chk("log pointer", 16'h0040, q[15:0]);
    ptr = 0;
    for (int i = 1; i <= 300; i++) begin
      hw(8'(i % 200 + 1));
      if (i <= 17) entry({8'h00, 8'(i % 200 + 1)}, 16'h0000);
      if (i == 16) begin
        bus(0, 5'h00, 0);
        chk("log pointer", 16'h1040, q[15:0]);
      end
    end
    bus(0, 5'h00, 0);
    chk("log pointer", 16'hFF58, q[15:0]);
    summarize();
  end
endmodule
